// [shared/ibs_pkg.sv]
/*
  ibs_pkg: constants and types of the two-wire bus block.
  Assumes a 100 MHz core clock; times become tick counts here.
*/
`default_nettype none
package ibs_pkg;

  // clock and time base
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned TICK_NS = 100;
  localparam int unsigned TICK_CYCLES = TICK_NS / CLK_PERIOD_NS;
  localparam int unsigned T_LOW_NS = 4700;
  localparam int unsigned T_HIGH_NS = 4000;
  // least times, rounded up to whole ticks
  localparam int unsigned T_LOW_TICKS = (T_LOW_NS + TICK_NS - 1) / TICK_NS;
  localparam int unsigned T_HIGH_TICKS = (T_HIGH_NS + TICK_NS - 1) / TICK_NS;
  localparam logic [3:0] TICK_LAST = 4'(TICK_CYCLES - 1);
  localparam logic [5:0] LOW_LAST = 6'(T_LOW_TICKS - 1);
  localparam logic [5:0] HIGH_LAST = 6'(T_HIGH_TICKS - 1);
  localparam logic [5:0] PHASE_ZERO = 6'h00;
  localparam logic [3:0] TICK_ZERO = 4'h0;

  // interface mode select encodings
  localparam logic [1:0] MODE_RESET = 2'h0;
  localparam logic [1:0] MODE_I2C = 2'h2;

  // soft reset field sequence
  localparam logic [1:0] SRST_IDLE = 2'h0;
  localparam logic [1:0] SRST_ARM = 2'h2;
  localparam logic [1:0] SRST_FIRE = 2'h1;

  // bit positions within a nine-clock frame
  localparam logic [3:0] BIT_FIRST = 4'h0;
  localparam logic [3:0] BIT_LAST = 4'h7;
  localparam logic [3:0] BIT_ACK = 4'h8;
  localparam logic [3:0] BIT_DONE = 4'h9;
  localparam logic [7:0] GENERAL_CALL = 8'h00;
  localparam logic [7:0] DATA_ZERO = 8'h00;

  // master clock generator states
  typedef enum logic [2:0] {
    M_IDLE,
    M_START,
    M_LOW,
    M_HIGH,
    M_STOP_LOW,
    M_STOP_HIGH
  } ibs_mstate_type;

endpackage : ibs_pkg
`default_nettype wire

// [logic/ibs_line_sync.sv]
/*
  ibs_line_sync: syncs the bus pins, finds SCL edges, START and STOP.
  Assumes pins change no faster than a few core clocks.
*/
`timescale 1ns/10ps
`default_nettype none
module ibs_line_sync
  import ibs_pkg::*;
(
  // clock and reset
  input wire logic core_clk_i,
  input wire logic nrst_i,
  // raw bus levels
  input wire logic scl_i,
  input wire logic sda_i,
  // synchronised levels and events
  output logic scl_s_o,
  output logic sda_s_o,
  output logic scl_rise_o,
  output logic scl_fall_o,
  output logic start_det_o,
  output logic stop_det_o
);

  logic scl_meta_r;
  logic sda_meta_r;
  logic scl_sync_r;
  logic sda_sync_r;
  logic scl_prev_r;
  logic sda_prev_r;

  // two sync flops per pin, one history flop
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      scl_meta_r <= 1'b1;
      sda_meta_r <= 1'b1;
      scl_sync_r <= 1'b1;
      sda_sync_r <= 1'b1;
      scl_prev_r <= 1'b1;
      sda_prev_r <= 1'b1;
    end else begin
      scl_meta_r <= scl_i;
      sda_meta_r <= sda_i;
      scl_sync_r <= scl_meta_r;
      sda_sync_r <= sda_meta_r;
      scl_prev_r <= scl_sync_r;
      sda_prev_r <= sda_sync_r;
    end
  end

  // edges and line conditions from stage two
  assign scl_s_o = scl_sync_r;
  assign sda_s_o = sda_sync_r;
  assign scl_rise_o = scl_sync_r & ~scl_prev_r; // RULE25
  assign scl_fall_o = ~scl_sync_r & scl_prev_r;
  assign start_det_o = scl_sync_r & scl_prev_r & sda_prev_r & ~sda_sync_r;
  assign stop_det_o = scl_sync_r & scl_prev_r & ~sda_prev_r & sda_sync_r;

endmodule : ibs_line_sync
`default_nettype wire

// [logic/ibs_bus_ctrl.sv]
/*
  ibs_bus_ctrl: two-wire bus status and control in I2C mode.
  Assumes strobes on core_clk_i; open-drain pins resolved outside.
*/
// Function
// (RULE1) word end: clear wait, pulse irq; hold SCL low while 0
// (RULE2) data write (send) or read (receive) sets wait
// (RULE3) SCL released one low period after wait sets
// (RULE4) recognised address clears wait
// (RULE5) write 1 sets wait; write 0 ignored
// (RULE6) mode 10 selects I2C
// (RULE7) port mode only on a free bus; code takes the mode on any control write
// (RULE8) START on busy bus: lost, nothing driven
// (RULE9) master checks SDA at each SCL rise
// (RULE10) lost master releases SDA
// (RULE11) arbitration spans every word
// (RULE12) losing sets lost flag, clears master and transmit
// (RULE13) data access or control write clears lost flag
// (RULE14) addressed on match, or first word if recognition off
// (RULE15) data access clears addressed flag
// (RULE16) zero first byte sets general call
// (RULE17) START or STOP clears general call
// (RULE18) last bit samples SDA at SCL rise
// (RULE19) soft reset 10 then 01 resets all; field back to 00
// (RULE20) soft reset leaves synchronous mode
// (RULE21) recognition off: all frames free data
// (RULE22) baud generator enabled before bus use
// (RULE23) busy set on START, cleared on STOP
// (RULE24) start on free bus sends START and 8 bits
// (RULE25) one clock; pins synchronised before edges
`timescale 1ns/10ps
`default_nettype none
module ibs_bus_ctrl
  import ibs_pkg::*;
(
  // clock and reset
  input wire logic core_clk_i,
  input wire logic nrst_i,
  // control register two write
  input wire logic ctl2_wr_i,
  input wire logic ctl2_master_select_i,
  input wire logic ctl2_transmit_select_i,
  input wire logic ctl2_bus_busy_i,
  input wire logic ctl2_service_wait_i,
  input wire logic [1:0] ctl2_mode_select_i,
  input wire logic [1:0] ctl2_soft_reset_i,
  // data buffer access
  input wire logic dbuf_wr_i,
  input wire logic [7:0] dbuf_wdata_i,
  input wire logic dbuf_rd_i,
  // static configuration
  input wire logic [6:0] own_slave_address_i,
  input wire logic address_recognition_disable_i,
  input wire logic ack_mode_i,
  input wire logic baud_generator_enable_i,
  // status
  output logic master_select_o,
  output logic transmit_select_o,
  output logic bus_busy_flag_o,
  output logic service_wait_o,
  output logic arbitration_lost_flag_o,
  output logic addressed_as_slave_flag_o,
  output logic general_call_flag_o,
  output logic last_received_bit_o,
  output logic [1:0] interface_mode_select_o,
  output logic [1:0] soft_reset_field_o,
  output logic [7:0] data_buffer_o,
  output logic serial_bus_irq_o,
  // bus pins
  input wire logic scl_i,
  output logic scl_o,
  output logic scl_oe_o,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o
);

  ibs_mstate_type m_state_r;
  logic scl_s, sda_s, scl_rise, scl_fall, start_det, stop_det;
  logic [3:0] tick_cnt_r;
  logic [5:0] phase_r;
  logic [3:0] bit_cnt_r;
  logic [7:0] rx_sr_r;
  logic [7:0] tx_buf_r;
  logic [1:0] mode_r;
  logic [1:0] srst_field_r;
  logic srst_armed_r, soft_rst_r;
  logic mst_r, trx_r, busy_r, pin_r, al_r, aas_r, gc_r, lrb_r;
  logic first_word_r, addr_act_r, ack_drive_r, stop_req_r;
  logic sda_low_r, scl_low_r, irq_r;
  logic i2c_on, tick_en, tx_bit, word_done, serviced, byte_done;
  logic slave_rx_first, addr_match, free_first, gc_event, addressed;
  logic start_cmd, start_go, start_refused, stop_cmd, al_event;
  logic master_addr_ack, sw_pin_set, slave_hold;
  logic [7:0] byte_in;
  logic [3:0] drive_idx;

  ibs_line_sync u_sync (
    .core_clk_i(core_clk_i),
    .nrst_i(nrst_i),
    .scl_i(scl_i),
    .sda_i(sda_i),
    .scl_s_o(scl_s),
    .sda_s_o(sda_s),
    .scl_rise_o(scl_rise),
    .scl_fall_o(scl_fall),
    .start_det_o(start_det),
    .stop_det_o(stop_det)
  );

  ////////////////////////////////////////////////////////////////////////////
  // decoded events

  assign i2c_on = (mode_r == MODE_I2C); // RULE6
  assign tick_en = baud_generator_enable_i & (tick_cnt_r == TICK_LAST); // RULE22
  assign tx_bit = tx_buf_r[~bit_cnt_r[2:0]];
  assign byte_in = {rx_sr_r[6:0], sda_s};
  assign byte_done = i2c_on & scl_rise & (bit_cnt_r == BIT_LAST);
  assign word_done = i2c_on & scl_fall & (bit_cnt_r == BIT_DONE);
  // only a master or an addressed slave owns the word end
  assign serviced = word_done & (mst_r | addr_act_r);
  assign slave_rx_first = first_word_r & ~mst_r & byte_done;
  assign addr_match = slave_rx_first & ~address_recognition_disable_i &
                      ((byte_in[7:1] == own_slave_address_i) | (byte_in == GENERAL_CALL));
  assign free_first = slave_rx_first & address_recognition_disable_i; // RULE21
  assign gc_event = slave_rx_first & (byte_in == GENERAL_CALL); // RULE16
  assign addressed = addr_match | free_first;
  assign start_cmd = ctl2_wr_i & i2c_on & ctl2_master_select_i & ctl2_transmit_select_i &
                     ctl2_bus_busy_i & ctl2_service_wait_i;
  assign start_go = start_cmd & ~busy_r & (m_state_r == M_IDLE); // RULE24
  assign start_refused = start_cmd & busy_r; // RULE8
  assign stop_cmd = ctl2_wr_i & i2c_on & ctl2_master_select_i & ctl2_transmit_select_i &
                    ~ctl2_bus_busy_i & ctl2_service_wait_i & busy_r & mst_r;
  // released bit read low, any word
  assign al_event = start_refused |
                    (i2c_on & mst_r & trx_r & scl_rise & (bit_cnt_r < BIT_ACK) &
                     tx_bit & ~sda_s); // RULE9 RULE11
  assign master_addr_ack = mst_r & first_word_r & scl_rise & (bit_cnt_r == BIT_ACK) & ~sda_s;
  assign sw_pin_set = (ctl2_wr_i & ctl2_service_wait_i) | (dbuf_wr_i & trx_r) |
                      (dbuf_rd_i & ~trx_r); // RULE2 RULE5
  assign slave_hold = ~mst_r & addr_act_r & busy_r & (bit_cnt_r == BIT_FIRST) & ~pin_r;

  ////////////////////////////////////////////////////////////////////////////
  // soft reset: arm on 10, fire on a following 01

  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      srst_field_r <= SRST_IDLE;
      srst_armed_r <= 1'b0;
      soft_rst_r <= 1'b0;
    end else if (soft_rst_r) begin
      srst_field_r <= SRST_IDLE; // RULE19
      srst_armed_r <= 1'b0;
      soft_rst_r <= 1'b0;
    end else if (ctl2_wr_i) begin
      srst_field_r <= ctl2_soft_reset_i;
      srst_armed_r <= (ctl2_soft_reset_i == SRST_ARM);
      soft_rst_r <= srst_armed_r & (ctl2_soft_reset_i == SRST_FIRE); // RULE19
    end
  end

  // mode select; resets to synchronous mode
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      mode_r <= MODE_RESET;
    end else if (soft_rst_r) begin
      mode_r <= MODE_RESET; // RULE20
    end else if (ctl2_wr_i) begin
      mode_r <= ctl2_mode_select_i;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // tick divider and master clock generator

  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      tick_cnt_r <= TICK_ZERO;
    end else if (!baud_generator_enable_i || tick_en) begin
      tick_cnt_r <= TICK_ZERO;
    end else begin
      tick_cnt_r <= tick_cnt_r + 4'h1;
    end
  end

  // high phase waits for the line: stretch tolerant
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      m_state_r <= M_IDLE;
      phase_r <= PHASE_ZERO;
    end else if (soft_rst_r || !i2c_on) begin
      m_state_r <= M_IDLE;
      phase_r <= PHASE_ZERO;
    end else begin
      unique case (m_state_r)
        M_IDLE: begin
          phase_r <= PHASE_ZERO;
          if (start_go) begin
            m_state_r <= M_START;
          end
        end
        M_START: begin
          if (tick_en && phase_r == HIGH_LAST) begin
            m_state_r <= M_LOW;
            phase_r <= PHASE_ZERO;
          end else if (tick_en) begin
            phase_r <= phase_r + 6'h01;
          end
        end
        M_LOW: begin
          if (!mst_r) begin
            m_state_r <= M_IDLE; // RULE10
          end else if (bit_cnt_r == BIT_FIRST && !pin_r) begin
            phase_r <= PHASE_ZERO; // RULE1 RULE3
          end else if (tick_en && phase_r == LOW_LAST) begin
            phase_r <= PHASE_ZERO;
            m_state_r <= (bit_cnt_r == BIT_FIRST && stop_req_r) ? M_STOP_LOW : M_HIGH;
          end else if (tick_en) begin
            phase_r <= phase_r + 6'h01;
          end
        end
        M_HIGH: begin
          if (!mst_r) begin
            m_state_r <= M_IDLE;
          end else if (!scl_s) begin
            phase_r <= PHASE_ZERO;
          end else if (tick_en && phase_r == HIGH_LAST) begin
            phase_r <= PHASE_ZERO;
            m_state_r <= M_LOW;
          end else if (tick_en) begin
            phase_r <= phase_r + 6'h01;
          end
        end
        M_STOP_LOW: begin
          if (tick_en && phase_r == LOW_LAST) begin
            phase_r <= PHASE_ZERO;
            m_state_r <= M_STOP_HIGH;
          end else if (tick_en) begin
            phase_r <= phase_r + 6'h01;
          end
        end
        M_STOP_HIGH: begin
          if (!scl_s) begin
            phase_r <= PHASE_ZERO;
          end else if (tick_en && phase_r == HIGH_LAST) begin
            m_state_r <= M_IDLE;
          end else if (tick_en) begin
            phase_r <= phase_r + 6'h01;
          end
        end
      endcase
    end
  end

  // stop request, taken at next word boundary
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      stop_req_r <= 1'b0;
    end else if (soft_rst_r || m_state_r == M_STOP_LOW || m_state_r == M_IDLE) begin
      stop_req_r <= stop_cmd;
    end else if (stop_cmd) begin
      stop_req_r <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // frame tracking: bit count, shift registers, data buffer

  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      bit_cnt_r <= BIT_FIRST;
      first_word_r <= 1'b0;
    end else if (soft_rst_r || start_det) begin
      bit_cnt_r <= BIT_FIRST;
      first_word_r <= start_det;
    end else if (word_done) begin
      bit_cnt_r <= BIT_FIRST;
      first_word_r <= 1'b0;
    end else if (scl_rise && bit_cnt_r < BIT_DONE) begin
      bit_cnt_r <= bit_cnt_r + 4'h1;
    end
  end

  // receive shifter and read buffer
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rx_sr_r <= DATA_ZERO;
      data_buffer_o <= DATA_ZERO;
    end else if (soft_rst_r) begin
      rx_sr_r <= DATA_ZERO;
      data_buffer_o <= DATA_ZERO;
    end else if (scl_rise && bit_cnt_r < BIT_ACK) begin
      rx_sr_r <= byte_in;
      if (byte_done) begin
        data_buffer_o <= byte_in;
      end
    end
  end

  // transmit buffer; msb goes out first
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      tx_buf_r <= DATA_ZERO;
    end else if (soft_rst_r) begin
      tx_buf_r <= DATA_ZERO;
    end else if (dbuf_wr_i) begin
      tx_buf_r <= dbuf_wdata_i;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // status flags; a hardware set beats a same-cycle clear

  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      busy_r <= 1'b0;
    end else if (soft_rst_r) begin
      busy_r <= 1'b0;
    end else if (i2c_on && start_det) begin
      busy_r <= 1'b1; // RULE23
    end else if (stop_det) begin
      busy_r <= 1'b0; // RULE23
    end
  end

  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      mst_r <= 1'b0;
    end else if (soft_rst_r || al_event || stop_det) begin
      mst_r <= 1'b0; // RULE12
    end else if (ctl2_wr_i) begin
      mst_r <= ctl2_master_select_i;
    end
  end

  // direction bit drives transmit select
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      trx_r <= 1'b0;
    end else if (soft_rst_r || al_event || stop_det) begin
      trx_r <= 1'b0; // RULE12
    end else if (addr_match) begin
      trx_r <= byte_in[0];
    end else if (master_addr_ack) begin
      trx_r <= ~tx_buf_r[0];
    end else if (ctl2_wr_i) begin
      trx_r <= ctl2_transmit_select_i;
    end
  end

  // software set beats word-end clear
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pin_r <= 1'b1;
    end else if (soft_rst_r) begin
      pin_r <= 1'b1;
    end else if (sw_pin_set) begin
      pin_r <= 1'b1; // RULE2 RULE5
    end else if (serviced) begin
      pin_r <= 1'b0; // RULE1 RULE4
    end
  end

  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      al_r <= 1'b0;
    end else if (soft_rst_r) begin
      al_r <= 1'b0;
    end else if (al_event) begin
      al_r <= 1'b1; // RULE12
    end else if (dbuf_wr_i || dbuf_rd_i || ctl2_wr_i) begin
      al_r <= 1'b0; // RULE13
    end
  end

  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      aas_r <= 1'b0;
      addr_act_r <= 1'b0;
    end else if (soft_rst_r) begin
      aas_r <= 1'b0;
      addr_act_r <= 1'b0;
    end else begin
      if (addressed) begin
        aas_r <= 1'b1; // RULE14
      end else if (dbuf_wr_i || dbuf_rd_i) begin
        aas_r <= 1'b0; // RULE15
      end
      if (addressed) begin
        addr_act_r <= 1'b1;
      end else if (start_det || stop_det) begin
        addr_act_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      gc_r <= 1'b0;
    end else if (soft_rst_r) begin
      gc_r <= 1'b0;
    end else if (gc_event) begin
      gc_r <= 1'b1; // RULE16
    end else if (start_det || stop_det) begin
      gc_r <= 1'b0; // RULE17
    end
  end

  // holds the ack level after the ninth rise
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      lrb_r <= 1'b0;
    end else if (soft_rst_r) begin
      lrb_r <= 1'b0;
    end else if (i2c_on && scl_rise) begin
      lrb_r <= sda_s; // RULE18
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pin drivers: SDA bits move only while SCL low

  // ack decided at 8th rise, dropped at word end
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ack_drive_r <= 1'b0;
    end else if (soft_rst_r || word_done || start_det) begin
      ack_drive_r <= 1'b0;
    end else if (byte_done) begin
      ack_drive_r <= ack_mode_i & (addressed |
                     (~first_word_r & ~trx_r & (mst_r | addr_act_r)));
    end
  end

  assign drive_idx = (bit_cnt_r == BIT_DONE) ? BIT_FIRST : bit_cnt_r;

  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      sda_low_r <= 1'b0;
    end else if (soft_rst_r || !i2c_on) begin
      sda_low_r <= 1'b0;
    end else if (m_state_r == M_START || m_state_r == M_STOP_LOW ||
                 m_state_r == M_STOP_HIGH) begin
      sda_low_r <= 1'b1;
    end else if (!busy_r || !(mst_r || addr_act_r)) begin
      sda_low_r <= 1'b0; // RULE10
    end else if (!scl_s) begin
      if (drive_idx == BIT_ACK) begin
        sda_low_r <= ack_drive_r;
      end else begin
        // lost master has trx cleared, so it lets SDA float
        sda_low_r <= trx_r & (mst_r | addr_act_r) & ~tx_buf_r[~drive_idx[2:0]]; // RULE10
      end
    end
  end

  // SCL low from the generator or a waiting slave
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      scl_low_r <= 1'b0;
    end else if (soft_rst_r || !i2c_on) begin
      scl_low_r <= 1'b0;
    end else begin
      scl_low_r <= (m_state_r == M_LOW) | (m_state_r == M_STOP_LOW) | slave_hold; // RULE1
    end
  end

  // irq pulse at end of an owned word
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      irq_r <= 1'b0;
    end else if (soft_rst_r) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= serviced; // RULE1
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs

  assign master_select_o = mst_r;
  assign transmit_select_o = trx_r;
  assign bus_busy_flag_o = busy_r;
  assign service_wait_o = pin_r;
  assign arbitration_lost_flag_o = al_r;
  assign addressed_as_slave_flag_o = aas_r;
  assign general_call_flag_o = gc_r;
  assign last_received_bit_o = lrb_r;
  assign interface_mode_select_o = mode_r;
  assign soft_reset_field_o = srst_field_r;
  assign serial_bus_irq_o = irq_r;
  assign scl_o = 1'b0;
  assign scl_oe_o = scl_low_r;
  assign sda_o = 1'b0;
  assign sda_oe_o = sda_low_r;

endmodule : ibs_bus_ctrl
`default_nettype wire

// [tb/ibs_bus_ctrl_assertions.sv]
/* ibs_bus_ctrl_assertions: port checks for ibs_bus_ctrl.
   Assumes a bind, one clock, async low reset. */
`timescale 1ns/10ps
`default_nettype none
module ibs_bus_ctrl_assertions
  import ibs_pkg::*;
(
  // clock, reset and strobes
  input wire logic core_clk_i, input wire logic nrst_i, input wire logic ctl2_wr_i,
  input wire logic ctl2_master_select_i, input wire logic ctl2_transmit_select_i,
  input wire logic ctl2_bus_busy_i, input wire logic ctl2_service_wait_i,
  input wire logic [1:0] ctl2_soft_reset_i, input wire logic dbuf_wr_i, input wire logic dbuf_rd_i,
  // status and pins
  input wire logic master_select_o, input wire logic transmit_select_o,
  input wire logic bus_busy_flag_o, input wire logic service_wait_o,
  input wire logic arbitration_lost_flag_o, input wire logic [1:0] interface_mode_select_o,
  input wire logic [1:0] soft_reset_field_o, input wire logic serial_bus_irq_o,
  input wire logic scl_oe_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!nrst_i);
  logic armed_r;
  wire logic start_cmd = ctl2_wr_i && ctl2_master_select_i && ctl2_transmit_select_i
    && ctl2_bus_busy_i && ctl2_service_wait_i;
  // last control write armed soft reset
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) armed_r <= 1'b0;
    else if (ctl2_wr_i) armed_r <= (ctl2_soft_reset_i == SRST_ARM);
  end
  ////////////////////////////////////////////////////////////////////////////
  irq_clears_wait_a: assert property (serial_bus_irq_o |-> !service_wait_o)
    else $error("irq without wait clear");
  scl_held_low_a: assert property (!service_wait_o && master_select_o |-> scl_oe_o)
    else $error("clock not held low");
  wait_set_a: assert property (ctl2_wr_i && ctl2_service_wait_i |=> service_wait_o)
    else $error("wait not set by write");
  data_sets_wait_a: assert property (dbuf_wr_i && transmit_select_o |=> service_wait_o)
    else $error("wait not set by data write");
  busy_start_a: assert property (start_cmd && bus_busy_flag_o |=> arbitration_lost_flag_o)
    else $error("busy start not lost");
  lost_roles_a: assert property ($rose(arbitration_lost_flag_o)
    |-> ##[0:1] (!master_select_o && !transmit_select_o)) else $error("roles kept");
  lost_clear_a: assert property ((dbuf_rd_i || dbuf_wr_i) && !master_select_o && !ctl2_wr_i
    |=> !arbitration_lost_flag_o) else $error("lost flag kept");
  soft_reset_a: assert property (ctl2_wr_i && armed_r && ctl2_soft_reset_i == SRST_FIRE
    |-> ##3 (interface_mode_select_o == MODE_RESET && soft_reset_field_o == SRST_IDLE
    && service_wait_o && !master_select_o)) else $error("soft reset failed");
  cover property (serial_bus_irq_o);
  cover property ($rose(arbitration_lost_flag_o));
  cover property (ctl2_wr_i && armed_r && ctl2_soft_reset_i == SRST_FIRE);
endmodule : ibs_bus_ctrl_assertions
`default_nettype wire

// [tb/ibs_slave_model.sv]
/* ibs_slave_model: bus slave that acknowledges every byte after a START.
   Assumes resolved open-drain levels with pull-ups on both lines. */
`timescale 1ns/10ps
`default_nettype none
module ibs_slave_model (
  // resolved bus levels
  input wire logic scl_i, input wire logic sda_i,
  // high pulls data low
  output logic sda_oe_o
);
  int unsigned bits_r = 0;
  initial sda_oe_o = 1'b0;
  // START restarts the clock count
  always @(negedge sda_i) if (scl_i) bits_r = 0;
  // acks every ninth clock; answers any address
  always @(negedge scl_i) begin
    bits_r = bits_r + 1;
    sda_oe_o = (bits_r % 9 == 0);
  end
endmodule : ibs_slave_model
`default_nettype wire

// [tb/tb.sv]
/* tb: control writes, data strobes and bus checks.
   Assumes the acking slave model and pull-ups. */
`timescale 1ns/10ps
`default_nettype none
module tb;
  import ibs_pkg::*;
  logic core_clk_i = 1'b0, nrst_i = 1'b0, ctl2_wr_i = 1'b0, wr_i = 1'b0, rd_i = 1'b0;
  logic m_i = 1'b0, t_i = 1'b0, b_i = 1'b0, p_i = 1'b0;
  logic [1:0] mode_i = 2'h0, srst_i = 2'h0, mode_o, srst_o;
  logic [7:0] wdata_i = 8'hA4, dbuf_o;
  logic ms_o, ts_o, bb_o, sw_o, al_o, lrb_o, irq_o, aas_o, gc_o, scl_oe, sda_oe, slv_oe;
  int bad_count = 0, total_checks = 0;
  // open-drain wires with pull-ups
  wire logic scl_w = !scl_oe;
  wire logic sda_w = !(sda_oe || slv_oe);
  always #5 core_clk_i = !core_clk_i;
  ibs_bus_ctrl ibs_bus_ctrl_inst (.core_clk_i(core_clk_i), .nrst_i(nrst_i), .ctl2_wr_i(ctl2_wr_i),
    .ctl2_master_select_i(m_i), .ctl2_transmit_select_i(t_i), .ctl2_bus_busy_i(b_i),
    .ctl2_service_wait_i(p_i), .ctl2_mode_select_i(mode_i), .ctl2_soft_reset_i(srst_i),
    .dbuf_wr_i(wr_i), .dbuf_wdata_i(wdata_i), .dbuf_rd_i(rd_i), .own_slave_address_i(7'h3C),
    .address_recognition_disable_i(1'b0), .ack_mode_i(1'b1), .baud_generator_enable_i(1'b1),
    .master_select_o(ms_o), .transmit_select_o(ts_o), .bus_busy_flag_o(bb_o),
    .service_wait_o(sw_o), .arbitration_lost_flag_o(al_o), .addressed_as_slave_flag_o(aas_o),
    .general_call_flag_o(gc_o), .last_received_bit_o(lrb_o), .interface_mode_select_o(mode_o),
    .soft_reset_field_o(srst_o), .data_buffer_o(dbuf_o), .serial_bus_irq_o(irq_o),
    .scl_i(scl_w), .scl_o(), .scl_oe_o(scl_oe), .sda_i(sda_w), .sda_o(), .sda_oe_o(sda_oe));
  ibs_slave_model ibs_slave_model_inst (.scl_i(scl_w), .sda_i(sda_w), .sda_oe_o(slv_oe));
  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check
  // control write, then settle
  task automatic ctl2(input logic m, t, b, p, input logic [1:0] sr);
    @(negedge core_clk_i);
    {m_i, t_i, b_i, p_i, srst_i, mode_i, ctl2_wr_i} = {m, t, b, p, sr, MODE_I2C, 1'b1};
    @(negedge core_clk_i);
    ctl2_wr_i = 1'b0;
    repeat (2) @(negedge core_clk_i);
  endtask : ctl2
  task automatic pulse(input logic w, r);
    @(negedge core_clk_i);
    {wr_i, rd_i} = {w, r};
    @(negedge core_clk_i);
    {wr_i, rd_i} = 2'b00;
    repeat (2) @(negedge core_clk_i);
  endtask : pulse
  task automatic wait_irq();
    int n;
    for (n = 0; n < 20000 && irq_o !== 1'b1; n++) @(negedge core_clk_i);
    if (n == 20000) begin
      bad_count++;
      report_and_stop();
    end
  endtask : wait_irq
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : report_and_stop
  ////////////////////////////////////////////////////////////////////////////
  // address byte A4 is a write, so transmit stays selected after the ack
  initial begin
    repeat (12) @(negedge core_clk_i);
    nrst_i = 1'b1;
    check({sw_o, al_o, ms_o, bb_o, mode_o}, 6'b100000);
    ctl2(1'b0, 1'b0, 1'b0, 1'b0, SRST_IDLE);
    check({sw_o, mode_o}, {1'b1, MODE_I2C});
    pulse(1'b1, 1'b0);
    ctl2(1'b1, 1'b1, 1'b1, 1'b1, SRST_IDLE);
    wait_irq();
    check({sw_o, ms_o, ts_o, aas_o, gc_o}, 5'b01100);
    repeat (4) @(negedge core_clk_i);
    check({scl_w, lrb_o, bb_o}, 3'b001);
    check(dbuf_o, 8'hA4);
    wdata_i = 8'h3C;
    pulse(1'b1, 1'b0);
    check(sw_o, 1'b1);
    repeat (400) @(negedge core_clk_i);
    check(scl_w, 1'b0);
    repeat (100) @(negedge core_clk_i);
    check(scl_w, 1'b1);
    ctl2(1'b1, 1'b1, 1'b1, 1'b1, SRST_IDLE);
    check({al_o, ms_o, ts_o, sda_oe}, 4'b1000);
    pulse(1'b0, 1'b1);
    check(al_o, 1'b0);
    ctl2(1'b0, 1'b0, 1'b0, 1'b1, SRST_ARM);
    ctl2(1'b0, 1'b0, 1'b0, 1'b1, SRST_FIRE);
    check({mode_o, srst_o, sw_o}, {MODE_RESET, SRST_IDLE, 1'b1});
    report_and_stop();
  end
endmodule : tb
bind ibs_bus_ctrl ibs_bus_ctrl_assertions ibs_chk (.core_clk_i(core_clk_i), .nrst_i(nrst_i),
  .ctl2_wr_i(ctl2_wr_i), .ctl2_master_select_i(ctl2_master_select_i),
  .ctl2_transmit_select_i(ctl2_transmit_select_i), .ctl2_bus_busy_i(ctl2_bus_busy_i),
  .ctl2_service_wait_i(ctl2_service_wait_i), .ctl2_soft_reset_i(ctl2_soft_reset_i),
  .dbuf_wr_i(dbuf_wr_i), .dbuf_rd_i(dbuf_rd_i), .master_select_o(master_select_o),
  .transmit_select_o(transmit_select_o), .bus_busy_flag_o(bus_busy_flag_o),
  .service_wait_o(service_wait_o), .arbitration_lost_flag_o(arbitration_lost_flag_o),
  .interface_mode_select_o(interface_mode_select_o), .soft_reset_field_o(soft_reset_field_o),
  .serial_bus_irq_o(serial_bus_irq_o), .scl_oe_o(scl_oe_o));
`default_nettype wire
